// >>> hw/caf_consts.vh
// Constants for the content-addressable address filter
`ifndef CAF_CONSTS_VH
`define CAF_CONSTS_VH
`define CAF_ENTRIES      32
`define CAF_IDX_W        5
`define CAF_AW           48
`define CAF_ADDR_W       4
// Register indices
`define CAF_REG_CMD      4'h0
`define CAF_REG_STAT     4'h1
`define CAF_REG_CMP_LO   4'h2
`define CAF_REG_CMP_HI   4'h3
`define CAF_REG_MSK_LO   4'h4
`define CAF_REG_MSK_HI   4'h5
`define CAF_REG_ATTR     4'h6
`define CAF_REG_RB_DLO   4'h7
`define CAF_REG_RB_DHI   4'h8
`define CAF_REG_RB_MLO   4'h9
`define CAF_REG_RB_MHI   4'ha
`define CAF_REG_RB_ATTR  4'hb
`define CAF_REG_MATCH    4'hc
// Commands
`define CAF_CMD_NOP      3'h0
`define CAF_CMD_WRITE    3'h1
`define CAF_CMD_SEARCH   3'h2
`define CAF_CMD_READBACK 3'h3
`define CAF_CMD_SKIP     3'h4
`define CAF_CMD_UNSKIP   3'h5
`define CAF_CMD_INVAL    3'h6
`define CAF_CMD_CLRERR   3'h7
// Attribute bit positions
`define CAF_AT_VALID     0
`define CAF_AT_SKIP      1
`define CAF_AT_SA        2
`define CAF_AT_SAX       3
`define CAF_AT_DA        4
`define CAF_AT_DAX       5
`define CAF_AT_W         6
// Status bit positions
`define CAF_ST_DONE      0
`define CAF_ST_HIT       1
`define CAF_ST_MANY      2
`define CAF_ST_ERR       3
`define CAF_ST_W         4
`define CAF_ATTR_RST     6'h00
`define CAF_STAT_RST     4'h1
`endif

// >>> hw/caf_filter.v
// Address filter array, host command engine and register port
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "caf_consts.vh"
module caf_filter
(
  // Clock and reset
  input  wire                    MCLK_I,
  input  wire                    RESET_I,
  // Register port
  input  wire [`CAF_ADDR_W-1:0]  ADDR_I,
  input  wire [31:0]             WDATA_I,
  input  wire                    WR_I,
  input  wire                    RD_I,
  output reg  [31:0]             RDATA_O,
  // Frame address lookups
  input  wire [`CAF_AW-1:0]      SRC_ADDR_I,
  input  wire [`CAF_AW-1:0]      DST_ADDR_I,
  output reg                     SRC_MATCH_O,
  output reg                     SRC_EXACT_O,
  output reg                     DST_MATCH_O,
  output reg                     DST_EXACT_O,
  output reg                     ALL_MATCH_O,
  output reg  [`CAF_ENTRIES-1:0] SRC_MATCH_VEC_O,
  // Command finished
  output reg                     DONE_O
);
  reg  [`CAF_AW-1:0]       data_ff [0:`CAF_ENTRIES-1];
  reg  [`CAF_AW-1:0]       mask_ff [0:`CAF_ENTRIES-1];
  reg  [`CAF_AT_W-1:0]     attr_ff [0:`CAF_ENTRIES-1];
  reg  [`CAF_AW-1:0]       cmp_ff;
  reg  [`CAF_AW-1:0]       hmask_ff;
  reg  [`CAF_AT_W-1:0]     hattr_ff;
  reg  [`CAF_ST_W-1:0]     stat_ff;
  reg  [`CAF_IDX_W-1:0]    sel_ff;
  reg                      sel_ok_ff;
  reg  [`CAF_AW-1:0]       rb_data_ff;
  reg  [`CAF_AW-1:0]       rb_mask_ff;
  reg  [`CAF_AT_W-1:0]     rb_attr_ff;
  wire [`CAF_ENTRIES-1:0]  src_m;
  wire [`CAF_ENTRIES-1:0]  src_x;
  wire [`CAF_ENTRIES-1:0]  dst_m;
  wire [`CAF_ENTRIES-1:0]  dst_x;
  wire [`CAF_ENTRIES-1:0]  host_m;
  wire [`CAF_IDX_W-1:0]    wr_slot;
  wire [`CAF_IDX_W-1:0]    hit_idx;
  reg  [`CAF_ENTRIES-1:0]  cand;
  reg  [`CAF_ENTRIES-1:0]  free;
  reg  [`CAF_AW-1:0]       nxt_rdata;
  wire                     cmd_wr;
  wire [2:0]               cmd;
  integer                  k;
  integer                  j;

  // Lowest set bit index
  function [`CAF_IDX_W-1:0] first_idx;
    input [`CAF_ENTRIES-1:0] v;
    integer i;
    begin
      first_idx = {`CAF_IDX_W{1'b0}};
      for (i = `CAF_ENTRIES - 1; i >= 0; i = i - 1)
        if (v[i])
          first_idx = i[`CAF_IDX_W-1:0];
    end
  endfunction

  // More than one bit set
  function many_set;
    input [`CAF_ENTRIES-1:0] v;
    begin
      many_set = |(v & (v - {{(`CAF_ENTRIES-1){1'b0}}, 1'b1}));
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < `CAF_ENTRIES; g = g + 1)
    begin : g_ent
      caf_match_line u_line
      (
        .data_i       (data_ff[g]),
        .mask_i       (mask_ff[g]),
        .attr_i       (attr_ff[g]),
        .src_i        (SRC_ADDR_I),
        .dst_i        (DST_ADDR_I),
        .host_i       (cmp_ff),
        .src_match_o  (src_m[g]),
        .src_exact_o  (src_x[g]),
        .dst_match_o  (dst_m[g]),
        .dst_exact_o  (dst_x[g]),
        .host_match_o (host_m[g]),
        .raw_src_o    ()
      );
    end
  endgenerate

  always @*
  begin
    for (k = 0; k < `CAF_ENTRIES; k = k + 1)
    begin
      cand[k] = host_m[k] & ~attr_ff[k][`CAF_AT_SKIP];
      free[k] = ~attr_ff[k][`CAF_AT_VALID];
    end
  end

  // One encoder each, shared by every use of the slot and the winner
  assign wr_slot = first_idx(free);
  assign hit_idx = first_idx(cand);

  // Lookup outputs registered
  always @(posedge MCLK_I)
  begin
    if (RESET_I)
    begin
      SRC_MATCH_O     <= 1'b0;
      SRC_EXACT_O     <= 1'b0;
      DST_MATCH_O     <= 1'b0;
      DST_EXACT_O     <= 1'b0;
      ALL_MATCH_O     <= 1'b0;
      SRC_MATCH_VEC_O <= {`CAF_ENTRIES{1'b0}};
    end
    else
    begin
      SRC_MATCH_O     <= |src_m;
      SRC_EXACT_O     <= |src_x;
      DST_MATCH_O     <= |dst_m;
      DST_EXACT_O     <= |dst_x;
      ALL_MATCH_O     <= &src_m;
      SRC_MATCH_VEC_O <= src_m;
    end
  end

  assign cmd_wr = WR_I && (ADDR_I == `CAF_REG_CMD);
  assign cmd    = WDATA_I[2:0];

  // Host registers and command engine
  always @(posedge MCLK_I)
  begin
    if (RESET_I)
    begin
      cmp_ff     <= {`CAF_AW{1'b0}};
      hmask_ff   <= {`CAF_AW{1'b0}};
      hattr_ff   <= `CAF_ATTR_RST;
      stat_ff    <= `CAF_STAT_RST;
      sel_ff     <= {`CAF_IDX_W{1'b0}};
      sel_ok_ff  <= 1'b0;
      rb_data_ff <= {`CAF_AW{1'b0}};
      rb_mask_ff <= {`CAF_AW{1'b0}};
      rb_attr_ff <= `CAF_ATTR_RST;
      for (j = 0; j < `CAF_ENTRIES; j = j + 1)
      begin
        data_ff[j] <= {`CAF_AW{1'b0}};
        mask_ff[j] <= {`CAF_AW{1'b0}};
        attr_ff[j] <= `CAF_ATTR_RST;
      end
    end
    else
    begin
      if (WR_I)
      begin
        if (ADDR_I == `CAF_REG_CMP_LO)
          cmp_ff[31:0] <= WDATA_I;
        else if (ADDR_I == `CAF_REG_CMP_HI)
          cmp_ff[`CAF_AW-1:32] <= WDATA_I[`CAF_AW-33:0];
        else if (ADDR_I == `CAF_REG_MSK_LO)
          hmask_ff[31:0] <= WDATA_I;
        else if (ADDR_I == `CAF_REG_MSK_HI)
          hmask_ff[`CAF_AW-1:32] <= WDATA_I[`CAF_AW-33:0];
        else if (ADDR_I == `CAF_REG_ATTR)
          hattr_ff <= WDATA_I[`CAF_AT_W-1:0];
      end
      if (cmd_wr)
      begin
        // done set on completion
        // Commands finish on the edge they are taken, so done never drops
        // done completes each command
        stat_ff[`CAF_ST_DONE] <= 1'b1;
        case (cmd)
          `CAF_CMD_WRITE:
          begin
            if (|free)
            begin
              data_ff[wr_slot] <= cmp_ff;
              mask_ff[wr_slot] <= hmask_ff;
              attr_ff[wr_slot] <= hattr_ff;
            end
            else
              stat_ff[`CAF_ST_ERR] <= 1'b1;
          end
          `CAF_CMD_SEARCH:
          begin
            stat_ff[`CAF_ST_HIT]  <= |cand;
            stat_ff[`CAF_ST_MANY] <= many_set(cand);
            sel_ff                <= hit_idx;
            sel_ok_ff             <= |cand;
          end
          `CAF_CMD_READBACK:
          begin
            if (sel_ok_ff)
            begin
              rb_data_ff <= data_ff[sel_ff];
              rb_mask_ff <= mask_ff[sel_ff];
              rb_attr_ff <= attr_ff[sel_ff];
            end
          end
          `CAF_CMD_SKIP:
          begin
            if (sel_ok_ff)
              attr_ff[sel_ff][`CAF_AT_SKIP] <= 1'b1;
          end
          `CAF_CMD_UNSKIP:
          begin
            for (j = 0; j < `CAF_ENTRIES; j = j + 1)
              attr_ff[j][`CAF_AT_SKIP] <= 1'b0;
          end
          `CAF_CMD_INVAL:
          begin
            if (sel_ok_ff)
              attr_ff[sel_ff][`CAF_AT_VALID] <= 1'b0;
            sel_ok_ff <= 1'b0;
          end
          `CAF_CMD_CLRERR:
            stat_ff[`CAF_ST_ERR] <= 1'b0;
          default:
            stat_ff[`CAF_ST_DONE] <= 1'b1;
        endcase
      end
    end
  end

  // Read mux
  always @*
  begin
    nxt_rdata = {`CAF_AW{1'b0}};
    if (ADDR_I == `CAF_REG_STAT)
      nxt_rdata[`CAF_ST_W-1:0] = stat_ff;
    else if (ADDR_I == `CAF_REG_CMP_LO)
      nxt_rdata[31:0] = cmp_ff[31:0];
    else if (ADDR_I == `CAF_REG_CMP_HI)
      nxt_rdata[`CAF_AW-33:0] = cmp_ff[`CAF_AW-1:32];
    else if (ADDR_I == `CAF_REG_MSK_LO)
      nxt_rdata[31:0] = hmask_ff[31:0];
    else if (ADDR_I == `CAF_REG_MSK_HI)
      nxt_rdata[`CAF_AW-33:0] = hmask_ff[`CAF_AW-1:32];
    else if (ADDR_I == `CAF_REG_ATTR)
      nxt_rdata[`CAF_AT_W-1:0] = hattr_ff;
    else if (ADDR_I == `CAF_REG_RB_DLO)
      nxt_rdata[31:0] = rb_data_ff[31:0];
    else if (ADDR_I == `CAF_REG_RB_DHI)
      nxt_rdata[`CAF_AW-33:0] = rb_data_ff[`CAF_AW-1:32];
    else if (ADDR_I == `CAF_REG_RB_MLO)
      nxt_rdata[31:0] = rb_mask_ff[31:0];
    else if (ADDR_I == `CAF_REG_RB_MHI)
      nxt_rdata[`CAF_AW-33:0] = rb_mask_ff[`CAF_AW-1:32];
    else if (ADDR_I == `CAF_REG_RB_ATTR)
      nxt_rdata[`CAF_AT_W-1:0] = rb_attr_ff;
    else if (ADDR_I == `CAF_REG_MATCH)
      nxt_rdata[31:0] = src_m;
  end

  always @(posedge MCLK_I)
  begin
    if (RESET_I)
    begin
      RDATA_O <= 32'h0000_0000;
      DONE_O  <= 1'b0;
    end
    else
    begin
      RDATA_O <= RD_I ? nxt_rdata[31:0] : 32'h0000_0000;
      DONE_O  <= stat_ff[`CAF_ST_DONE];
    end
  end
endmodule
`default_nettype wire

// >>> hw/caf_match_line.v
// One address filter entry comparator with attribute qualification
`timescale 1ns/1ps
`default_nettype none
`include "caf_consts.vh"
module caf_match_line
(
  // Stored entry
  input  wire [`CAF_AW-1:0]   data_i,
  input  wire [`CAF_AW-1:0]   mask_i,
  input  wire [`CAF_AT_W-1:0] attr_i,
  // Comparands
  input  wire [`CAF_AW-1:0]   src_i,
  input  wire [`CAF_AW-1:0]   dst_i,
  input  wire [`CAF_AW-1:0]   host_i,
  // Results
  output wire                 src_match_o,
  output wire                 src_exact_o,
  output wire                 dst_match_o,
  output wire                 dst_exact_o,
  output wire                 host_match_o,
  output wire                 raw_src_o
);
  wire valid;
  wire raw_src;
  wire raw_dst;
  wire raw_host;
  assign valid = attr_i[`CAF_AT_VALID];
  assign raw_src  = &(~mask_i | ~(data_i ^ src_i));
  assign raw_dst  = &(~mask_i | ~(data_i ^ dst_i));
  assign raw_host = &(~mask_i | ~(data_i ^ host_i));
  assign raw_src_o = raw_src;
  assign src_match_o = valid & attr_i[`CAF_AT_SA] & raw_src;
  assign src_exact_o = src_match_o & attr_i[`CAF_AT_SAX];
  assign dst_match_o = valid & attr_i[`CAF_AT_DA] & raw_dst;
  assign dst_exact_o = dst_match_o & attr_i[`CAF_AT_DAX];
  assign host_match_o = valid & raw_host;
endmodule
`default_nettype wire

// >>> tb/caf_filter_props.sv
// Port-level assertions for the address filter
`timescale 1ns/1ps
`default_nettype none
`include "caf_consts.vh"
module caf_filter_props
(
  // Clock and reset
  input wire logic                    MCLK_I,
  input wire logic                    RESET_I,
  // Register port
  input wire logic [`CAF_ADDR_W-1:0]  ADDR_I,
  input wire logic [31:0]             WDATA_I,
  input wire logic                    WR_I,
  input wire logic                    RD_I,
  input wire logic [31:0]             RDATA_O,
  // Lookups
  input wire logic [`CAF_AW-1:0]      SRC_ADDR_I,
  input wire logic [`CAF_AW-1:0]      DST_ADDR_I,
  input wire logic                    SRC_MATCH_O,
  input wire logic                    SRC_EXACT_O,
  input wire logic                    DST_MATCH_O,
  input wire logic                    DST_EXACT_O,
  input wire logic                    ALL_MATCH_O,
  input wire logic [`CAF_ENTRIES-1:0] SRC_MATCH_VEC_O,
  // Completion
  input wire logic                    DONE_O
);
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (RESET_I);
  // Array only changes on commands, so quiet inputs give quiet lines
  sequence src_quiet;
    (!WR_I && $stable(SRC_ADDR_I)) [*2];
  endsequence
  sequence rst_seen;
    RESET_I;
  endsequence
  reset_clear_a: assert property (disable iff (1'b0)
    rst_seen |=> RDATA_O == 32'h0 && !SRC_MATCH_O && !ALL_MATCH_O)
    else $error("outputs not cleared by reset");
  rdata_idle_a: assert property (!RD_I |=> RDATA_O == 32'h0)
    else $error("read data without a read");
  src_exact_a: assert property (SRC_EXACT_O |-> SRC_MATCH_O)
    else $error("source exact without source match");
  dst_exact_a: assert property (DST_EXACT_O |-> DST_MATCH_O)
    else $error("destination exact without match");
  any_match_a: assert property (SRC_MATCH_O == (|SRC_MATCH_VEC_O))
    else $error("match is not the OR of entries");
  all_match_a: assert property (ALL_MATCH_O == (&SRC_MATCH_VEC_O))
    else $error("all-match disagrees with entries");
  done_high_a: assert property (!RESET_I ##1 !RESET_I |=> DONE_O)
    else $error("done dropped");
  stat_done_a: assert property (
    RD_I && ADDR_I == `CAF_REG_STAT |=> RDATA_O[`CAF_ST_DONE])
    else $error("status read without done");
  unmapped_read_a: assert property (RD_I && ADDR_I > `CAF_REG_MATCH
    |=> RDATA_O == 32'h0) else $error("unmapped read not zero");
  quiet_src_a: assert property (
    src_quiet ##1 1'b1 |-> $stable(SRC_MATCH_VEC_O))
    else $error("match lines moved without cause");
endmodule
`default_nettype wire

// >>> tb/caf_host_model.sv
// Node processor model driving the register port
`timescale 1ns/1ps
`default_nettype none
`include "caf_consts.vh"
module caf_host_model
(
  // Clock
  input  wire logic        clk_i,
  // Register port
  output var  logic [3:0]  addr_o,
  output var  logic [31:0] wdata_o,
  output var  logic        wr_o,
  output var  logic        rd_o,
  input  wire logic [31:0] rdata_i,
  input  wire logic        done_i
);
  initial
  begin
    addr_o = 4'h0;
    wdata_o = 32'h0;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1;
    d = rdata_i;
  endtask
  task automatic put48(input logic [3:0] a, input logic [47:0] v);
    wr(a, v[31:0]);
    wr(a + 4'h1, {16'h0, v[47:32]});
  endtask
  task automatic cmd(input logic [2:0] c, output logic [31:0] st);
    int n = 0;
    wr(`CAF_REG_CMD, {29'h0, c});
    while (done_i !== 1'b1 && n < 64)
    begin
      @(posedge clk_i);
      n++;
    end
    rd(`CAF_REG_STAT, st);
  endtask
endmodule
`default_nettype wire

// >>> tb/cam_address_filter_match_test.sv
// Self-checking bench for the address filter
`timescale 1ns/1ps
`default_nettype none
`include "caf_consts.vh"
module cam_address_filter_match_test;
  logic        clk, rst, wr, rd, sm, sx, dm, dx, am, done;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata, st, vec;
  logic [47:0] src, dst, d, a;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  caf_host_model h (.clk_i(clk), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd), .rdata_i(rdata), .done_i(done));
  caf_filter dut (.MCLK_I(clk), .RESET_I(rst), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .SRC_ADDR_I(src), .DST_ADDR_I(dst), .SRC_MATCH_O(sm),
    .SRC_EXACT_O(sx), .DST_MATCH_O(dm), .DST_EXACT_O(dx),
    .ALL_MATCH_O(am), .SRC_MATCH_VEC_O(vec), .DONE_O(done));
  task automatic chk(string nm, logic [47:0] seen, logic [47:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic look(logic [47:0] s, logic [47:0] t);
    @(posedge clk);
    src <= s;
    dst <= t;
    @(posedge clk);
    #1;
  endtask
  task automatic ent(logic [47:0] v, logic [47:0] m, logic [5:0] at);
    h.put48(`CAF_REG_CMP_LO, v);
    h.put48(`CAF_REG_MSK_LO, m);
    h.wr(`CAF_REG_ATTR, {26'h0, at});
    h.cmd(`CAF_CMD_WRITE, st);
  endtask
  // Entry 0 exact, entry 1 ignores the low byte
  function automatic logic [31:0] ev(logic [47:0] x);
    return {30'h0, x[47:8] == d[47:8], x == d};
  endfunction
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      bad_count++;
      complete_run;
    end
  end
  initial
  begin
    rst = 1'b1;
    src = 48'h0;
    dst = 48'h0;
    void'($urandom(32'hb099));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    h.rd(`CAF_REG_STAT, st);
    chk("stat", st, `CAF_STAT_RST);
    h.rd(4'hf, st);
    chk("unmapped", st, 48'h0);
    $display("test reset done");
    d = 48'({$urandom, $urandom});
    // Skip bits stay clear on entries written here
    ent(d, '1, 6'h1d);
    chk("wr0", st, 48'h1);
    ent(d ^ 48'hff, {40'hff_ffff_ffff, 8'h0}, 6'h35);
    ent(d, '1, 6'h04);
    for (int i = 0; i < 24; i++)
    begin
      a = (i == 0) ? d : d ^ (48'h1 << ($urandom % 48));
      look(a, a ^ 48'h0f);
      chk("look", {sm, sx, dm, dx, am, vec},
        {|ev(a), a == d, ev(a) > 1, ev(a) > 1, 1'b0,
         ev(a)});
    end
    $display("test lookup done");
    h.put48(`CAF_REG_CMP_LO, d);
    // A cleared host mask must not blank the comparand
    h.put48(`CAF_REG_MSK_LO, 48'h0);
    h.cmd(`CAF_CMD_SEARCH, st);
    chk("find", st, 48'h7);
    chk("done", done, 48'h1);
    h.cmd(`CAF_CMD_READBACK, st);
    h.rd(`CAF_REG_RB_DLO, st);
    chk("rb data", st, d[31:0]);
    h.rd(`CAF_REG_RB_ATTR, st);
    chk("rb attr", st, 48'h1d);
    h.rd(`CAF_REG_RB_DHI, st);
    chk("rb data hi", st, {16'h0, d[47:32]});
    h.rd(`CAF_REG_RB_MHI, st);
    chk("rb mask", st, 48'hffff);
    h.cmd(`CAF_CMD_SKIP, st);
    h.cmd(`CAF_CMD_SEARCH, st);
    chk("skip", st, 48'h3);
    h.cmd(`CAF_CMD_INVAL, st);
    h.cmd(`CAF_CMD_SEARCH, st);
    chk("inval", st, 48'h1);
    h.cmd(`CAF_CMD_UNSKIP, st);
    h.cmd(`CAF_CMD_SEARCH, st);
    chk("unskip", st, 48'h3);
    h.cmd(`CAF_CMD_INVAL, st);
    h.cmd(`CAF_CMD_SEARCH, st);
    chk("empty", st, 48'h1);
    h.cmd(`CAF_CMD_NOP, st);
    chk("nop", st, 48'h1);
    h.rd(`CAF_REG_CMP_LO, st);
    chk("cmp", st, d[31:0]);
    h.rd(`CAF_REG_MSK_HI, st);
    chk("host mask", st, 48'h0);
    look(d, d);
    chk("gone", {sm, dm, vec}, 48'h0);
    h.rd(`CAF_REG_MATCH, st);
    chk("match reg", st, 48'h0);
    $display("test search done");
    // Stale error cleared before writing
    h.cmd(`CAF_CMD_CLRERR, st);
    for (int i = 0; i < 32; i++)
    begin
      ent(d, '1, 6'h05);
      chk("fill", st, 48'h1);
    end
    look(d, d);
    chk("all", {am, sx, dm, vec}, {1'b1, 1'b0, 1'b0, 32'hffff_ffff});
    ent(d, '1, 6'h05);
    chk("full", st, 48'h9);
    ent(d, '1, 6'h05);
    chk("sticky", st, 48'h9);
    h.cmd(`CAF_CMD_CLRERR, st);
    chk("clr", st, 48'h1);
    $display("test fill done");
    complete_run;
  end
endmodule
bind caf_filter caf_filter_props chk_i (.MCLK_I(MCLK_I), .RESET_I(RESET_I),
  .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
  .RDATA_O(RDATA_O), .SRC_ADDR_I(SRC_ADDR_I), .DST_ADDR_I(DST_ADDR_I),
  .SRC_MATCH_O(SRC_MATCH_O), .SRC_EXACT_O(SRC_EXACT_O),
  .DST_MATCH_O(DST_MATCH_O), .DST_EXACT_O(DST_EXACT_O),
  .ALL_MATCH_O(ALL_MATCH_O), .SRC_MATCH_VEC_O(SRC_MATCH_VEC_O),
  .DONE_O(DONE_O));
`default_nettype wire
